//--- hw/lmc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bus wake pulse end enters awake
// - awake waits for host enable high
// - recessive for first-dominant delay after normal entry
// - filtered enable rise wakes sleep to normal
// - latch wake level just before sleep
// - deglitched wake change leaves sleep to awake
// - awake to normal on filtered enable
// - power-on reset lands in awake
// - overheat cuts switch, bus recessive
// - undervoltage forces transmitter recessive in normal
// - transmit stuck low forces recessive
// - sleep: driver, switch off, receive floating
// - awake: switch on, receive low
// - preparation: weak pull-up, switch on
// - sleep after long enable low, stable wake
// - bus wake needs long dominant pulse
// - enable/transmit toggle flips fast baud
// - normal: transmit drives bus, receive mirrors
module lmc_mode_ctrl
    import lmc_pkg::*;
#(
    parameter int unsigned EN_FILT   = EN_FILT_TK,    // enable_wake_filter_time
    parameter int unsigned WAKE_DG   = WAKE_DG_TK,    // wake_pin_deglitch_time
    parameter int unsigned SLEEP_DLY = SLEEP_TK,      // sleep_entry_delay
    parameter int unsigned BUS_WAKE  = BUS_WAKE_TK,   // bus_wake_pulse_min
    parameter int unsigned FIRST_DOM = FIRST_DOM_TK,  // initial_dominant_delay
    parameter int unsigned TXD_STUCK = TXD_STUCK_TK,  // stuck transmit limit
    parameter int unsigned TICK_DIV  = TICK_CYC       // clocks per tick
) (
    input  wire logic               clk,                   // 25 MHz clock
    input  wire logic               arst_n,                // power-on reset, active low
    input  wire lmc_pkg::lmc_host_t host,                  // enable and transmit pins
    input  wire logic               wake_in,               // local wake switch level
    input  wire logic               bus_level,             // bus level, 1 = recessive
    input  wire lmc_pkg::lmc_fault_t faults,               // thermal and supply flags
    output var  logic               bus_drive_dom,         // driver pulls bus dominant
    output var  logic               bus_pullup_strong,     // strong pull-up connected
    output var  logic               regulator_switch_out,  // regulator switch on
    output var  logic               rx_out,                // receive pin level
    output var  logic               rx_out_en,             // receive pin driven
    output var  logic               fast_baud,             // fast baud selected
    output var  lmc_pkg::lmc_mode_t mode                   // current mode
);
    import lmc_pkg::*;

    lmc_state_t st_q;   // registered state
    lmc_state_t st_d;   // next state

    logic en_hi_ok;     // enable high for the filter time
    logic en_lo_ok;     // enable low for the filter time
    logic sleep_ok;     // enable low for the sleep delay
    logic wake_ok;      // wake differs from reference long enough
    logic bus_dom_ok;   // bus dominant long enough in sleep
    logic first_ok;     // initial dominant delay elapsed
    logic stuck;        // transmit held low too long

    // timers; every delay counts one-microsecond ticks
    lmc_hold_timer #(.N(EN_FILT)) u_en_hi (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick), .cond(host.en), .done(en_hi_ok));
    lmc_hold_timer #(.N(EN_FILT)) u_en_lo (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick), .cond(!host.en), .done(en_lo_ok));
    lmc_hold_timer #(.N(SLEEP_DLY)) u_sleep (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick), .cond(!host.en), .done(sleep_ok));
    lmc_hold_timer #(.N(WAKE_DG)) u_wake (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick),
        .cond(wake_in != st_q.wake_ref), .done(wake_ok));
    lmc_hold_timer #(.N(BUS_WAKE)) u_bus (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick),
        .cond(st_q.mode == LMC_SLEEP && !bus_level), .done(bus_dom_ok));
    lmc_hold_timer #(.N(FIRST_DOM)) u_first (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick),
        .cond(st_q.mode == LMC_NORMAL), .done(first_ok));
    lmc_hold_timer #(.N(TXD_STUCK)) u_stuck (
        .clk(clk), .arst_n(arst_n), .tick(st_q.tick),
        .cond(st_q.mode == LMC_NORMAL && !host.txd), .done(stuck));

    // next state: divider, modes, wake reference, toggle, outputs
    always_comb begin
        st_d = st_q;
        st_d.en_prev = host.en;

        // one-cycle tick every microsecond
        st_d.tick = (st_q.div == DIV_W'(TICK_DIV - 1));
        st_d.div  = st_d.tick ? '0 : st_q.div + DIV_W'(1);

        // mode sequencing
        unique case (st_q.mode)
            LMC_NORMAL: begin
                if (en_lo_ok) begin
                    st_d.mode = LMC_PREP;
                end
            end
            LMC_PREP: begin
                if (en_hi_ok) begin
                    st_d.mode = LMC_NORMAL;
                end else if (wake_ok) begin
                    // wake change settled before the sleep delay ran out
                    st_d.mode = LMC_AWAKE;
                end else if (sleep_ok) begin
                    st_d.mode = LMC_SLEEP;
                end
            end
            LMC_AWAKE: begin
                // stays here until the host raises enable
                if (en_hi_ok) begin
                    st_d.mode = LMC_NORMAL;
                end
            end
            LMC_SLEEP: begin
                if (en_hi_ok) begin
                    st_d.mode = LMC_NORMAL;
                end else if (wake_ok) begin
                    st_d.mode = LMC_AWAKE;
                end else if (st_q.bus_armed && bus_level) begin
                    st_d.mode = LMC_AWAKE;
                end
            end
        endcase

        // bus wake: armed by a long dominant, fired by the release edge
        if (st_d.mode != LMC_SLEEP) begin
            st_d.bus_armed = 1'b0;
        end else if (bus_dom_ok) begin
            st_d.bus_armed = 1'b1;
        end

        // reference follows wake while enabled outside sleep, frozen while enable is low
        // so a change during the sleep delay is still seen
        if (host.en && st_q.mode != LMC_SLEEP) begin
            st_d.wake_ref = wake_in;
        end
        if (st_d.mode == LMC_SLEEP && st_q.mode != LMC_SLEEP) begin
            st_d.wake_ref = wake_in;
        end

        // baud toggle: enable low with transmit high, high-low-high, enable up
        if (st_q.tick && st_q.tg_cnt != '1) begin
            st_d.tg_cnt = st_q.tg_cnt + TOG_W'(1);
        end
        if (st_q.tick && st_q.tg_tot != '1) begin
            st_d.tg_tot = st_q.tg_tot + TOG_W'(1);
        end
        unique case (st_q.tg_st)
            LMC_TG_IDLE: begin
                if (st_q.en_prev && !host.en && host.txd
                    && st_q.mode inside {LMC_NORMAL, LMC_PREP}) begin
                    st_d.tg_st  = LMC_TG_HI1;
                    st_d.tg_cnt = '0;
                    st_d.tg_tot = '0;
                end
            end
            LMC_TG_HI1: begin
                if (host.en || st_q.tg_tot > TOG_W'(TOG_MAX_TK)) begin
                    st_d.tg_st = LMC_TG_IDLE;
                end else if (!host.txd) begin
                    st_d.tg_st  = (st_q.tg_cnt >= TOG_W'(TOG_MIN_TK)) ? LMC_TG_LO : LMC_TG_IDLE;
                    st_d.tg_cnt = '0;
                end
            end
            LMC_TG_LO: begin
                if (host.en || st_q.tg_tot > TOG_W'(TOG_MAX_TK)) begin
                    st_d.tg_st = LMC_TG_IDLE;
                end else if (host.txd) begin
                    st_d.tg_st  = (st_q.tg_cnt >= TOG_W'(TOG_MIN_TK)) ? LMC_TG_HI2 : LMC_TG_IDLE;
                    st_d.tg_cnt = '0;
                end
            end
            LMC_TG_HI2: begin
                if (!host.txd || st_q.tg_tot > TOG_W'(TOG_MAX_TK)) begin
                    st_d.tg_st = LMC_TG_IDLE;
                end else if (host.en) begin
                    st_d.tg_st = LMC_TG_IDLE;
                    if (st_q.tg_cnt >= TOG_W'(TOG_MIN_TK)) begin
                        st_d.fast = !st_q.fast;
                    end
                end
            end
        endcase

        // outputs follow the next mode so they line up with mode
        st_d.pull_strong = (st_d.mode == LMC_NORMAL);
        // regulator switch on outside sleep, cut by overheat
        st_d.reg_sw  = (st_d.mode != LMC_SLEEP) && !faults.over_temp;
        // dominant only in normal, after the first delay, with no fault
        st_d.bus_dom = (st_d.mode == LMC_NORMAL) && first_ok && !host.txd
                       && !stuck
                       && !faults.under_volt
                       && !faults.over_temp;
        unique case (st_d.mode)
            LMC_NORMAL: begin
                st_d.rx_oe = 1'b1;
                st_d.rx    = bus_level || faults.over_temp;
            end
            LMC_AWAKE: begin
                st_d.rx_oe = 1'b1;
                st_d.rx    = 1'b0;
            end
            default: begin
                // sleep and preparation leave receive floating
                st_d.rx_oe = 1'b0;
                st_d.rx    = 1'b1;
            end
        endcase
    end

    // state register; reset is the power-on event
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q             <= '0;
            st_q.mode        <= MODE_RST;
            st_q.en_prev     <= 1'b0;
            st_q.tg_st       <= LMC_TG_IDLE;
            st_q.reg_sw      <= 1'b1;
            st_q.rx          <= 1'b0;
            st_q.rx_oe       <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign bus_drive_dom        = st_q.bus_dom;
    assign bus_pullup_strong    = st_q.pull_strong;
    assign regulator_switch_out = st_q.reg_sw;
    assign rx_out               = st_q.rx;
    assign rx_out_en            = st_q.rx_oe;
    assign fast_baud            = st_q.fast;
    assign mode                 = st_q.mode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_sleep_quiet: assert property (
        st_q.mode == LMC_SLEEP |-> !regulator_switch_out && !rx_out_en && !bus_drive_dom)
        else $error("sleep outputs not quiet");
    a_awake_report: assert property (
        st_q.mode == LMC_AWAKE |-> rx_out_en && !rx_out && !bus_drive_dom)
        else $error("awake does not report wake");
    a_prep_outputs: assert property (
        st_q.mode == LMC_PREP |-> !bus_drive_dom && !rx_out_en && !bus_pullup_strong)
        else $error("preparation outputs wrong");
    a_first_dom_hold: assert property (
        $rose(st_q.mode == LMC_NORMAL) |-> !bus_drive_dom [*8])
        else $error("dominant before first delay");
    a_bus_wake_edge: assert property (
        st_q.mode == LMC_SLEEP && st_q.bus_armed && bus_level
        |=> st_q.mode inside {LMC_AWAKE, LMC_NORMAL})
        else $error("bus wake edge missed");
    a_awake_holds: assert property (
        st_q.mode == LMC_AWAKE && !host.en |=> st_q.mode == LMC_AWAKE)
        else $error("awake left without enable");
    a_uv_recessive: assert property (
        faults.under_volt |=> !bus_drive_dom)
        else $error("dominant under undervoltage");
    a_ot_shutdown: assert property (
        faults.over_temp |=> !regulator_switch_out && !bus_drive_dom)
        else $error("overheat not handled");
    a_rx_mirror: assert property (
        st_q.mode == LMC_NORMAL && st_d.mode == LMC_NORMAL && !faults.over_temp
        |=> rx_out_en && rx_out == $past(bus_level))
        else $error("receive does not mirror bus");
    a_sleep_ref: assert property (
        st_q.mode != LMC_SLEEP ##1 st_q.mode == LMC_SLEEP |-> st_q.wake_ref == $past(wake_in))
        else $error("wake reference not latched");
    a_stuck_cut: assert property (
        stuck |=> !bus_drive_dom)
        else $error("stuck transmit reaches bus");

    // filtered enable rise from sleep goes straight to normal
    a_enable_wake: assert property (
        st_q.mode == LMC_SLEEP && en_hi_ok |=> st_q.mode == LMC_NORMAL)
        else $error("enable wake missed");
    // settled wake pin change leaves sleep for awake
    a_pin_wake: assert property (
        st_q.mode == LMC_SLEEP && wake_ok && !en_hi_ok |=> st_q.mode == LMC_AWAKE)
        else $error("wake pin change missed");
    // quiet wake pin through the sleep delay ends in sleep
    a_sleep_entry: assert property (
        st_q.mode == LMC_PREP && sleep_ok && !en_hi_ok && !wake_ok
        |=> st_q.mode == LMC_SLEEP)
        else $error("sleep entry missed");
    // strong pull-up belongs to normal only
    a_normal_pullup: assert property (
        st_q.mode == LMC_NORMAL |-> bus_pullup_strong)
        else $error("pull-up not strong in normal");
    // switch stays on everywhere but sleep unless overheated
    a_switch_on: assert property (
        st_d.mode != LMC_SLEEP && !faults.over_temp |=> regulator_switch_out)
        else $error("regulator switch dropped");
    // arming only ever follows a long dominant seen in sleep
    a_armed_by_dominant: assert property (
        $rose(st_q.bus_armed) |-> $past(bus_dom_ok))
        else $error("bus wake armed without long dominant");
    // baud flips only at the closing enable rise of the sequence
    a_fast_toggle: assert property (
        $changed(fast_baud) |-> $past(st_q.tg_st) == LMC_TG_HI2 && $past(host.en))
        else $error("baud flipped outside toggle");
    // a dominant from the driver always traces back to a low transmit in normal
    a_dom_needs_tx: assert property (
        bus_drive_dom |-> st_q.mode == LMC_NORMAL && !$past(host.txd))
        else $error("dominant without transmit low");

endmodule

`default_nettype wire

//--- pkg/lmc_pkg.sv
package lmc_pkg;

    // clock and internal time base
    localparam int unsigned CLK_NS       = 40;
    localparam int unsigned TICK_NS      = 1000;
    localparam int unsigned TICK_CYC     = (TICK_NS + CLK_NS - 1) / CLK_NS;

    // delays in microseconds, toggle minimum in nanoseconds, as printed or as chosen
    localparam int unsigned EN_FILT_US   = 10;
    localparam int unsigned WAKE_DG_US   = 70;
    localparam int unsigned SLEEP_US     = 70;
    localparam int unsigned BUS_WAKE_US  = 100;
    localparam int unsigned FIRST_DOM_US = 20;
    localparam int unsigned TXD_STUCK_US = 5000;
    localparam int unsigned TOG_MAX_US   = 45;
    localparam int unsigned TOG_MIN_NS   = 12500;

    // delays as counts of one-microsecond ticks
    localparam int unsigned EN_FILT_TK   = EN_FILT_US * 1000 / TICK_NS;
    localparam int unsigned WAKE_DG_TK   = WAKE_DG_US * 1000 / TICK_NS;
    localparam int unsigned SLEEP_TK     = (SLEEP_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int unsigned BUS_WAKE_TK  = (BUS_WAKE_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int unsigned FIRST_DOM_TK = (FIRST_DOM_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int unsigned TXD_STUCK_TK = TXD_STUCK_US * 1000 / TICK_NS;
    localparam int unsigned TOG_MAX_TK   = TOG_MAX_US * 1000 / TICK_NS;
    localparam int unsigned TOG_MIN_TK   = (TOG_MIN_NS + TICK_NS - 1) / TICK_NS;

    // widths of internal counters
    localparam int unsigned DIV_W        = 5;
    localparam int unsigned TOG_W        = 7;

    // operating modes
    typedef enum logic [1:0] {
        LMC_SLEEP  = 2'b00,
        LMC_AWAKE  = 2'b01,
        LMC_NORMAL = 2'b10,
        LMC_PREP   = 2'b11
    } lmc_mode_t;

    // baud toggle sequence steps
    typedef enum logic [1:0] {
        LMC_TG_IDLE = 2'b00,
        LMC_TG_HI1  = 2'b01,
        LMC_TG_LO   = 2'b10,
        LMC_TG_HI2  = 2'b11
    } lmc_tog_t;

    // value after reset: awake, as after power-on
    localparam lmc_mode_t MODE_RST = LMC_AWAKE;

    // host pins
    typedef struct packed {
        logic en;   // enable pin, high = normal
        logic txd;  // transmit pin, low = dominant
    } lmc_host_t;

    // protection flags from the analog side
    typedef struct packed {
        logic over_temp;   // thermal shutdown flag
        logic under_volt;  // supply_rail below undervoltage_limit
    } lmc_fault_t;

    // whole state of the controller
    typedef struct packed {
        lmc_mode_t        mode;
        logic             en_prev;
        logic             wake_ref;
        logic             bus_armed;
        lmc_tog_t         tg_st;
        logic [TOG_W-1:0] tg_cnt;
        logic [TOG_W-1:0] tg_tot;
        logic             fast;
        logic [DIV_W-1:0] div;
        logic             tick;
        logic             bus_dom;
        logic             pull_strong;
        logic             reg_sw;
        logic             rx;
        logic             rx_oe;
    } lmc_state_t;

endpackage

//--- hw/lmc_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

// reports that cond has held for n ticks without a break
module lmc_hold_timer #(
    parameter int unsigned N = 1,
    parameter int unsigned W = $clog2(N + 1)
) (
    input  wire logic clk,     // system clock
    input  wire logic arst_n,  // async reset, active low
    input  wire logic tick,    // time base enable
    input  wire logic cond,    // level being timed
    output var  logic done     // cond held n ticks
);
    typedef struct packed {
        logic [W-1:0] cnt;   // ticks seen so far
        logic         done;  // target reached
    } lmc_tmr_t;

    lmc_tmr_t st_q;
    lmc_tmr_t st_d;

    // count up while cond holds, saturate at n, clear on any break
    always_comb begin
        st_d = st_q;
        if (!cond) begin
            st_d.cnt = '0;
        end else if (tick && st_q.cnt != W'(N)) begin
            st_d.cnt = st_q.cnt + W'(1);
        end
        st_d.done = cond && (st_d.cnt == W'(N));
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;

endmodule

`default_nettype wire

//--- testbench/lmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host microcontroller: drives enable and transmit, reads the receive pin
module lmc_host_model
    import lmc_pkg::*;
#(
    parameter int unsigned TICK_DIV = 2  // clocks per time-base tick
) (
    input  wire logic               clk,        // system clock
    input  wire logic               rx_out,     // receive level from the device
    input  wire logic               rx_out_en,  // receive pin driven
    output var  lmc_pkg::lmc_host_t host,       // enable and transmit pins
    output var  logic               rx_seen     // receive pin as the host reads it
);
    // board pull-up shows high while the device floats the receive line
    assign rx_seen = rx_out_en ? rx_out : 1'h1;

    // pins parked low enable, recessive transmit
    initial begin
        host = '{en: 1'h0, txd: 1'h1};
    end

    // hold the pins for n whole ticks, counting the edge that set them
    task automatic hold_ticks(input int n);
        repeat (n * TICK_DIV - 1) @(posedge clk);
    endtask

    // pins change only just after an edge
    task automatic pins(input logic en, input logic txd);
        @(posedge clk);
        host.en  <= en;
        host.txd <= txd;
    endtask

    // awake waits on the host: raise enable, transmit recessive
    task automatic go_normal();
        pins(1'h1, 1'h1);
    endtask

    // baud toggle; 14 tick phases leave one tick of margin over 13, total 42 < 45
    task automatic toggle(input int lo_ticks);
        pins(1'h0, 1'h1);
        hold_ticks(14);
        pins(1'h0, 1'h0);
        hold_ticks(lo_ticks);
        pins(1'h0, 1'h1);
        hold_ticks(14);
        pins(1'h1, 1'h1);
    endtask
endmodule

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
    import lmc_pkg::*;
    // shortened counts, in ticks of TD clocks
    localparam int TD = 2, EF = 3, WD = 4, SD = 60, BW = 4, FD = 9, TS = 20;

    logic       clk = 1'h0, arst_n = 1'h0, wake_in = 1'h0, remote_dom = 1'h0;
    lmc_fault_t faults = '0;              // thermal and supply flags
    lmc_host_t  host;                     // pins from the host model
    lmc_mode_t  mode;                     // device mode
    logic       bus_drive_dom, bus_pullup_strong, regulator_switch_out;
    logic       rx_out, rx_out_en, fast_baud, rx_seen, bus_level;
    int         errors = 0, comparisons = 0, cycles = 0;
    logic [31:0] seed = 32'h8675;         // fixed seed, repeatable run

    always #20 clk = ~clk;
    // wired bus: dominant if either node pulls it low
    assign bus_level = ~(bus_drive_dom | remote_dom);

    lmc_mode_ctrl #(.EN_FILT(EF), .WAKE_DG(WD), .SLEEP_DLY(SD), .BUS_WAKE(BW),
        .FIRST_DOM(FD), .TXD_STUCK(TS), .TICK_DIV(TD)) uut (
        .clk(clk), .arst_n(arst_n), .host(host), .wake_in(wake_in),
        .bus_level(bus_level), .faults(faults), .bus_drive_dom(bus_drive_dom),
        .bus_pullup_strong(bus_pullup_strong), .regulator_switch_out(regulator_switch_out),
        .rx_out(rx_out), .rx_out_en(rx_out_en), .fast_baud(fast_baud), .mode(mode));

    lmc_host_model #(.TICK_DIV(TD)) host_m (
        .clk(clk), .rx_out(rx_out), .rx_out_en(rx_out_en), .host(host), .rx_seen(rx_seen));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // transmitter is silenced by undervoltage and heat
    function automatic logic exp_dom(input logic txd, input logic uv, input logic ot);
        return !txd && !uv && !ot;
    endfunction

    // receive mirrors the wire, held high while overheated
    function automatic logic exp_rx(input logic dom, input logic rd, input logic ot);
        return ot ? 1'h1 : !(dom || rd);
    endfunction

    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // settle after n edges, away from the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for a mode, then compare
    task automatic wait_mode(input lmc_mode_t m, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if (mode === m) break;
            step(1);
        end
        `CHK(mode, m)
    endtask

    // hang guard, well above the planned run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        int   k;
        logic t, uv, ot, rd, fb, seen;
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        step(1);
        `CHK(mode, LMC_AWAKE)
        `CHK({regulator_switch_out, rx_seen, bus_drive_dom}, 3'h4)
        step(100);
        `CHK(mode, LMC_AWAKE)
        host_m.go_normal();
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        // first dominant held back after entry
        host_m.pins(1'h1, 1'h0);
        for (k = 0; k < (FD - 1) * TD - 2; k++) begin
            step(1);
            `CHK(bus_drive_dom, 1'h0)
        end
        for (k = 0; k < 4 * TD + 4 && bus_drive_dom !== 1'h1; k++) step(1);
        `CHK({bus_drive_dom, bus_pullup_strong}, 2'h3)
        // transmit stuck low is cut off, then recovers on release
        for (k = 0; k < (TS + 4) * TD && bus_drive_dom !== 1'h0; k++) step(1);
        `CHK(bus_drive_dom, 1'h0)
        `CHK(mode, LMC_NORMAL)
        host_m.pins(1'h1, 1'h1);
        host_m.pins(1'h1, 1'h0);
        step(3);
        `CHK(bus_drive_dom, 1'h1)
        // random traffic with faults and remote dominant mixed in
        for (k = 0; k < 150; k++) begin
            seed = lfsr_next(seed);
            t = seed[0] | (k % 4 == 0);  // bounded low runs stay clear of stuck time
            ot = seed[4:1] == 4'h0;
            uv = seed[7:5] == 3'h0;
            rd = seed[9];
            host_m.pins(1'h1, t);
            faults <= '{over_temp: ot, under_volt: uv};
            remote_dom <= rd;
            step(3);
            `CHK(bus_drive_dom, exp_dom(t, uv, ot))
            `CHK(rx_out, exp_rx(exp_dom(t, uv, ot), rd, ot))
            `CHK(regulator_switch_out, !ot)
        end
        @(posedge clk) faults <= '0;
        remote_dom <= 1'h0;
        // baud toggle flips, flips back, a short low phase aborts
        fb = fast_baud;
        host_m.toggle(14);
        step(3);
        `CHK(fast_baud, ~fb)
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.toggle(14);
        step(3);
        `CHK(fast_baud, fb)
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.toggle(5);
        step(3);
        `CHK(fast_baud, fb)
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        // preparation then sleep, transmit ignored
        host_m.pins(1'h0, 1'h1);
        step((EF + 3) * TD);
        `CHK(mode, LMC_PREP)
        host_m.pins(1'h0, 1'h0);
        step(3);
        `CHK({regulator_switch_out, bus_pullup_strong, bus_drive_dom}, 3'h4)
        wait_mode(LMC_SLEEP, (SD + 4) * TD);
        `CHK({regulator_switch_out, rx_out_en, bus_drive_dom, rx_seen}, 4'h1)
        // wake pin: a glitch is filtered, a held change wakes
        @(posedge clk) wake_in <= 1'h1;
        step(2 * TD);
        @(posedge clk) wake_in <= 1'h0;
        step(10);
        `CHK(mode, LMC_SLEEP)
        @(posedge clk) wake_in <= 1'h1;
        wait_mode(LMC_AWAKE, (WD + 2) * TD + 4);
        `CHK({regulator_switch_out, rx_seen}, 2'h2)
        host_m.go_normal();
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.pins(1'h0, 1'h1);
        wait_mode(LMC_SLEEP, (SD + EF + 6) * TD);
        // bus wake: short pulse ignored, long pulse wakes on its release
        @(posedge clk) remote_dom <= 1'h1;
        step(2 * TD);
        @(posedge clk) remote_dom <= 1'h0;
        step(6);
        `CHK(mode, LMC_SLEEP)
        @(posedge clk) remote_dom <= 1'h1;
        step((BW + 2) * TD);
        `CHK(mode, LMC_SLEEP)
        @(posedge clk) remote_dom <= 1'h0;
        step(3);
        `CHK({mode, regulator_switch_out, rx_seen}, {LMC_AWAKE, 2'h2})
        host_m.go_normal();
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.pins(1'h0, 1'h1);
        wait_mode(LMC_SLEEP, (SD + EF + 6) * TD);
        // reference latched high, so falling wake level wakes
        @(posedge clk) wake_in <= 1'h0;
        wait_mode(LMC_AWAKE, (WD + 2) * TD + 4);
        host_m.go_normal();
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.pins(1'h0, 1'h1);
        wait_mode(LMC_SLEEP, (SD + EF + 6) * TD);
        // enable wake: short pulse filtered, long one goes straight to normal
        host_m.pins(1'h1, 1'h1);
        host_m.pins(1'h0, 1'h1);
        step(10);
        `CHK(mode, LMC_SLEEP)
        host_m.pins(1'h1, 1'h1);
        seen = 1'h0;
        for (k = 0; k < (EF + 2) * TD + 6 && mode !== LMC_NORMAL; k++) begin
            step(1);
            seen |= (mode === LMC_AWAKE);
        end
        `CHK({seen, mode}, {1'h0, LMC_NORMAL})
        // reset in mid-run, then heat while awake
        host_m.pins(1'h0, 1'h1);
        @(posedge clk) arst_n <= 1'h0;
        step(2);
        `CHK(mode, LMC_AWAKE)
        @(posedge clk) arst_n <= 1'h1;
        faults <= '{over_temp: 1'h1, under_volt: 1'h0};
        step(3);
        `CHK({mode, regulator_switch_out}, {LMC_AWAKE, 1'h0})
        @(posedge clk) faults <= '0;
        step(3);
        `CHK({mode, regulator_switch_out}, {LMC_AWAKE, 1'h1})
        // a wake change inside the sleep delay lands in awake, not sleep
        host_m.go_normal();
        wait_mode(LMC_NORMAL, (EF + 2) * TD + 4);
        host_m.pins(1'h0, 1'h1);
        wait_mode(LMC_PREP, (EF + 3) * TD);
        @(posedge clk) wake_in <= 1'h1;
        wait_mode(LMC_AWAKE, (WD + 2) * TD + 4);
        wrap_up();
    end
endmodule

`undef CHK
`default_nettype wire
